//--- pswake_pkg.sv
// Package holding constants, types and register map of the power-save wake controller
package pswake_pkg;

  // ***************************************************
  // Register map (byte addresses on the AHB-Lite slave)
  // ***************************************************
  localparam logic [7:0] RESET_CAUSE_ADDR = 8'h00;
  localparam logic [7:0] OSC_CTRL_ADDR = 8'h04;
  localparam logic [7:0] WAKE_STATUS_ADDR = 8'h08;
  localparam logic [7:0] OSC_DELAY_ADDR = 8'h0c;

  // ***************************************************
  // Field positions
  // ***************************************************
  localparam int IDLE_WAKE_BIT = 2;
  localparam int SLEEP_WAKE_BIT = 3;
  localparam int WDT_TIMEOUT_BIT = 4;
  localparam int SLEEP_SELECT_BIT = 4;
  localparam int CLOCK_SEL_LSB = 8;
  localparam int CLOCK_SEL_W = 3;

  // ***************************************************
  // Reset values and timing
  // ***************************************************
  localparam logic [31:0] OSC_CTRL_RESET = 32'h0000_0000;
  localparam logic [15:0] OSC_DELAY_RESET = 16'h0010;
  localparam int PRIO_W = 3;

  typedef enum logic [4:0] {
    RUN_ST = 5'b00001,
    ENTER_ST = 5'b00010,
    IDLE_ST = 5'b00100,
    SLEEP_ST = 5'b01000,
    START_ST = 5'b10000
  } power_state_type;

  typedef enum logic [1:0] {
    RESUME_NONE = 2'h0,
    RESUME_VECTOR = 2'h1,
    RESUME_RESET = 2'h2,
    RESUME_NEXT = 2'h3
  } resume_type;

  typedef struct packed {
    logic valid;
    logic [PRIO_W-1:0] prio;
  } wake_req_type;

endpackage

//--- wake_arbiter.sv
// Picks the highest-priority enabled, operational interrupt source
`timescale 1ns/1ps
`default_nettype none
module wake_arbiter
  import pswake_pkg::*;
#(
  parameter int SOURCES = 8
) (
  input wire logic [SOURCES-1:0] pending,
  input wire logic [SOURCES-1:0] sourceEnable,
  input wire logic [SOURCES-1:0] operational,
  input wire logic [SOURCES*PRIO_W-1:0] sourcePrio,
  output wake_req_type best
);
  always_comb begin
    best = '0;
    for (int i = 0; i < SOURCES; i++) begin
      // Priority zero can never wake, so it never enters the race
      if (pending[i] && sourceEnable[i] && operational[i] &&
          sourcePrio[i*PRIO_W +: PRIO_W] != '0 && sourcePrio[i*PRIO_W +: PRIO_W] > best.prio) begin
        best.valid = 1'b1;
        best.prio = sourcePrio[i*PRIO_W +: PRIO_W];
      end
    end
  end
endmodule
`default_nettype wire

//--- sync2.sv
// Two-flop synchroniser for levels arriving from outside the clock domain
`timescale 1ns/1ps
`default_nettype none
module sync2 #(
  parameter int WIDTH = 1
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic [WIDTH-1:0] din,
  output logic [WIDTH-1:0] dout
);
  logic [WIDTH-1:0] stage;
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      stage <= '0;
      dout <= '0;
    end else begin
      stage <= din;
      dout <= stage;
    end
  end
endmodule
`default_nettype wire

//--- power_save_wake_control.sv
// Sleep and idle wake sequencing, reset-cause status and clock-change lock
//
// Behaviour
// R1 - Only enabled sources that run in the current low-power state may wake
// R2 - Wake source at or below CPU priority keeps CPU halted in idle
// R3 - Higher-priority source wakes, vectors to handler, then resumes after the wait
// R4 - Waking from idle sets the idle-wake status bit
// R5 - Waking from sleep sets the sleep-wake status bit
// R6 - A source with priority zero never wakes the device
// R7 - Oscillator start-up delay runs before the CPU resumes
// R8 - Watchdog time-out in low power raises an NMI to the reset vector
// R9 - Watchdog NMI wake is not a reset; state is kept
// R10 - Watchdog expiry sets the watchdog time-out status bit
// R11 - After exception return, execution continues after the wait
// R12 - Watchdog counter is cleared on every wake-up
// R13 - Interrupt during the wait instruction is held until entry completes
// R14 - Software clock mode changes are blocked while debugging
// R15 - Fail-safe monitor clock switches still apply while debugging
// R16 - Non-power-on reset in low power sets matching status bit, restarts at reset vector
// R17 - Power-on reset clears both idle and sleep status bits
// R18 - No dedicated pins; entry and exit come from internal logic only
// R19 - Wait with sleep-select bit clear enters idle, otherwise sleep
// R20 - Status bits hold until software clears them or power-on reset
//
// Local design decisions: the AHB-Lite interface to the registers and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module power_save_wake_control
  import pswake_pkg::*;
#(
  parameter int SOURCES = 8
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic porPulse,
  input wire logic sysResetPulse,
  input wire logic waitExec,
  input wire logic eretExec,
  input wire logic [PRIO_W-1:0] cpuPrio,
  input wire logic [SOURCES-1:0] irqPending,
  input wire logic [SOURCES-1:0] irqEnable,
  input wire logic [SOURCES-1:0] irqRunsInIdle,
  input wire logic [SOURCES-1:0] irqRunsInSleep,
  input wire logic [SOURCES*PRIO_W-1:0] irqPrio,
  input wire logic wdtExpire,
  input wire logic debugActive,
  input wire logic failSafeSwitch,
  input wire logic [CLOCK_SEL_W-1:0] failSafeClock,
  input wire logic oscNeedsStartup,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  output logic cpuHalt,
  output logic sysClockGate,
  output logic [1:0] resumeAction,
  output logic nmiReq,
  output logic wdtClear,
  output logic [CLOCK_SEL_W-1:0] clockSelect
);

  // ***************************************************
  // Registers and state
  // ***************************************************
  power_state_type state;
  logic wasSleep;
  logic idleWake;
  logic sleepWake;
  logic wdtTimeout;
  logic [31:0] oscCtrl;
  logic [15:0] oscDelay;
  logic [15:0] delayCnt;
  logic heldIrq;
  logic wdtWake;
  logic nmiPending;
  logic [1:0] pendingResume;
  logic [SOURCES-1:0] pendingSync;
  logic wdtSync;
  logic wrPend;
  logic [7:0] wrAddr;
  wake_req_type best;
  logic [SOURCES-1:0] operational;
  logic lowPower;
  logic wakeHigh;
  logic wakeLow;
  logic wdtEvent;
  logic resetWake;
  logic wakeNow;
  logic startDone;
  logic causeWrite;

  // Interrupt lines and watchdog may come from other clock domains
  sync2 #(.WIDTH(SOURCES)) irqSync (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .din(irqPending),
    .dout(pendingSync)
  );

  sync2 #(.WIDTH(1)) wdtSyncInst (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .din(wdtExpire),
    .dout(wdtSync)
  );

  // ***************************************************
  // Wake decision
  // ***************************************************
  assign operational = wasSleep ? irqRunsInSleep : irqRunsInIdle; // R1

  wake_arbiter #(.SOURCES(SOURCES)) arb (
    .pending(pendingSync),
    .sourceEnable(irqEnable),
    .operational(operational),
    .sourcePrio(irqPrio),
    .best(best)
  );

  assign lowPower = (state == IDLE_ST) || (state == SLEEP_ST);
  assign wakeHigh = lowPower && best.valid && (best.prio > cpuPrio); // R3 R6
  assign wakeLow = best.valid && (best.prio <= cpuPrio); // R2
  assign wdtEvent = lowPower && wdtSync; // R8
  assign resetWake = lowPower && sysResetPulse; // R16
  // Shared terms, so every wake path sees the same decision
  assign wakeNow = resetWake || wdtEvent || wakeHigh;
  assign startDone = (state == START_ST) && (delayCnt <= 16'h0001);
  assign causeWrite = wrPend && (wrAddr == RESET_CAUSE_ADDR);

  // ***************************************************
  // Power state machine
  // ***************************************************
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= RUN_ST;
      wasSleep <= 1'b0;
      delayCnt <= '0;
      pendingResume <= RESUME_NONE;
      heldIrq <= 1'b0;
    end else if (porPulse) begin
      state <= RUN_ST;
      wasSleep <= 1'b0;
      delayCnt <= '0;
      pendingResume <= RESUME_RESET;
      heldIrq <= 1'b0;
    end else begin
      unique case (state)
        RUN_ST: begin
          if (waitExec) begin
            state <= ENTER_ST;
            wasSleep <= oscCtrl[SLEEP_SELECT_BIT]; // R19
            heldIrq <= 1'b0;
          end
        end
        ENTER_ST: begin
          // Arrivals during entry are held off, then re-seen in the low-power state
          heldIrq <= heldIrq | best.valid; // R13
          state <= wasSleep ? SLEEP_ST : IDLE_ST;
        end
        IDLE_ST, SLEEP_ST: begin
          if (resetWake || wdtEvent || wakeHigh) begin
            state <= START_ST;
            delayCnt <= oscNeedsStartup ? oscDelay : 16'h0001; // R7
            pendingResume <= resetWake ? RESUME_RESET : wdtEvent ? RESUME_RESET : RESUME_VECTOR; // R8 R16
          end else if (state == SLEEP_ST && wakeLow) begin
            // From here on idle rules apply: idle sources and the idle status bit
            state <= IDLE_ST; // R2
            wasSleep <= 1'b0; // R2
          end
        end
        START_ST: begin
          if (delayCnt <= 16'h0001) begin
            state <= RUN_ST; // R7
          end else begin
            delayCnt <= delayCnt - 16'h0001;
          end
        end
      endcase
    end
  end

  assign cpuHalt = (state != RUN_ST); // R18
  assign sysClockGate = (state == SLEEP_ST);

  // One-cycle resume command to the CPU as the start-up delay finishes, or on return from a watchdog wake handler
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      resumeAction <= RESUME_NONE;
    end else if (startDone) begin
      resumeAction <= pendingResume; // R3 R8
    end else if (state == RUN_ST && eretExec && wdtWake) begin
      resumeAction <= RESUME_NEXT; // R11
    end else begin
      resumeAction <= RESUME_NONE;
    end
  end

  // NMI is not a reset: only the resume path changes, no peripheral reset is issued
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      nmiPending <= 1'b0;
    end else if (porPulse) begin
      // A power-on reset drops a watchdog wake still in flight
      nmiPending <= 1'b0;
    end else if (wdtEvent && !resetWake) begin
      nmiPending <= 1'b1; // R8
    end else if (startDone) begin
      nmiPending <= 1'b0;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      nmiReq <= 1'b0;
    end else begin
      nmiReq <= nmiPending && startDone; // R8 R9
    end
  end

  // Marks a watchdog wake whose handler has not returned yet
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      wdtWake <= 1'b0;
    end else if (porPulse) begin
      wdtWake <= 1'b0;
    end else if (nmiPending && startDone) begin
      wdtWake <= 1'b1;
    end else if (eretExec) begin
      wdtWake <= 1'b0; // R11
    end
  end

  // Clearing on every wake covers the race of a peripheral wake with an expiry
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      wdtClear <= 1'b0;
    end else begin
      // A power-on reset restarts the watchdog by itself
      wdtClear <= wakeNow && !porPulse; // R12
    end
  end

  // ***************************************************
  // Reset-cause status bits
  // ***************************************************
  // Set wins over a software clear in the same cycle, so no wake is lost
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      idleWake <= 1'b0;
    end else if (porPulse) begin
      idleWake <= 1'b0; // R17
    end else if (wakeNow && !wasSleep) begin
      idleWake <= 1'b1; // R4 R16
    end else if (causeWrite && !hwdata[IDLE_WAKE_BIT]) begin
      idleWake <= 1'b0; // R20
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      sleepWake <= 1'b0;
    end else if (porPulse) begin
      sleepWake <= 1'b0; // R17
    end else if (wakeNow && wasSleep) begin
      sleepWake <= 1'b1; // R5 R16
    end else if (causeWrite && !hwdata[SLEEP_WAKE_BIT]) begin
      sleepWake <= 1'b0; // R20
    end
  end

  // Sets on any expiry, not only in low power, so software always sees it
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      wdtTimeout <= 1'b0;
    end else if (porPulse) begin
      wdtTimeout <= 1'b0;
    end else if (wdtSync) begin
      wdtTimeout <= 1'b1; // R10
    end else if (causeWrite && !hwdata[WDT_TIMEOUT_BIT]) begin
      wdtTimeout <= 1'b0; // R20
    end
  end

  // ***************************************************
  // Oscillator control and clock-switch lock
  // ***************************************************
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      oscCtrl <= OSC_CTRL_RESET;
      oscDelay <= OSC_DELAY_RESET;
    end else begin
      if (failSafeSwitch) begin
        oscCtrl[CLOCK_SEL_LSB +: CLOCK_SEL_W] <= failSafeClock; // R15
      end else if (wrPend && wrAddr == OSC_CTRL_ADDR) begin
        oscCtrl[SLEEP_SELECT_BIT] <= hwdata[SLEEP_SELECT_BIT];
        if (!debugActive) begin
          oscCtrl[CLOCK_SEL_LSB +: CLOCK_SEL_W] <= hwdata[CLOCK_SEL_LSB +: CLOCK_SEL_W]; // R14
        end
      end
      if (wrPend && wrAddr == OSC_DELAY_ADDR) begin
        oscDelay <= (hwdata[15:0] == 16'h0000) ? 16'h0001 : hwdata[15:0];
      end
    end
  end

  assign clockSelect = oscCtrl[CLOCK_SEL_LSB +: CLOCK_SEL_W];

  // ***************************************************
  // AHB-Lite slave
  // ***************************************************
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      wrPend <= 1'b0;
      wrAddr <= '0;
      hrdata <= '0;
    end else begin
      wrPend <= hsel && hready && htrans[1] && hwrite;
      if (hsel && hready && htrans[1]) begin
        wrAddr <= haddr[7:0];
      end
      if (hsel && hready && htrans[1] && !hwrite) begin
        unique case (haddr[7:0])
          RESET_CAUSE_ADDR: hrdata <= 32'(wdtTimeout) << WDT_TIMEOUT_BIT
                                    | 32'(sleepWake) << SLEEP_WAKE_BIT
                                    | 32'(idleWake) << IDLE_WAKE_BIT;
          OSC_CTRL_ADDR: hrdata <= oscCtrl;
          WAKE_STATUS_ADDR: hrdata <= {24'h000000, wdtWake, heldIrq, 1'b0, state};
          OSC_DELAY_ADDR: hrdata <= {16'h0000, oscDelay};
          default: hrdata <= 32'h0000_0000;
        endcase
      end
    end
  end

endmodule
`default_nettype wire

//--- power_save_wake_control_assertions.sv
// Port-level assertions for the power-save wake controller
`timescale 1ns/1ps
`default_nettype none
module power_save_wake_control_assertions
  import pswake_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic porPulse,
  input wire logic waitExec,
  input wire logic debugActive,
  input wire logic failSafeSwitch,
  input wire logic [CLOCK_SEL_W-1:0] failSafeClock,
  input wire logic cpuHalt,
  input wire logic sysClockGate,
  input wire logic [1:0] resumeAction,
  input wire logic nmiReq,
  input wire logic wdtClear,
  input wire logic [CLOCK_SEL_W-1:0] clockSelect
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  a_nmi_reset_vector: assert property (nmiReq |-> resumeAction == RESUME_RESET)
    else $error("watchdog wake without reset vector");
  a_resume_one_cycle: assert property (resumeAction != RESUME_NONE |=> resumeAction == RESUME_NONE)
    else $error("resume pulse longer than one cycle");
  a_wake_then_run: assert property (resumeAction inside {RESUME_VECTOR, RESUME_RESET} |-> ##[0:1] !cpuHalt)
    else $error("CPU still halted after resume");
  a_clear_while_halted: assert property (wdtClear |-> cpuHalt && resumeAction == RESUME_NONE)
    else $error("watchdog clear outside the wake sequence");
  a_wait_enters: assert property (waitExec && !cpuHalt && !porPulse |=> cpuHalt)
    else $error("wait did not halt the CPU");
  a_gate_halted: assert property (sysClockGate |-> cpuHalt && !nmiReq)
    else $error("clock gated while CPU runs");
  a_debug_lock: assert property (debugActive && !failSafeSwitch && !$past(failSafeSwitch) |=> $stable(clockSelect))
    else $error("clock select changed under debug");
  a_failsafe_apply: assert property (failSafeSwitch ##1 !failSafeSwitch |-> clockSelect == $past(failSafeClock))
    else $error("fail-safe clock switch lost");
endmodule
bind power_save_wake_control power_save_wake_control_assertions chk (.core_clk(core_clk), .rst_n(rst_n),
  .porPulse(porPulse), .waitExec(waitExec), .debugActive(debugActive), .failSafeSwitch(failSafeSwitch),
  .failSafeClock(failSafeClock), .cpuHalt(cpuHalt), .sysClockGate(sysClockGate),
  .resumeAction(resumeAction), .nmiReq(nmiReq), .wdtClear(wdtClear), .clockSelect(clockSelect));
`default_nettype wire

//--- cpu_model.sv
// CPU start-up code model: returns from the watchdog wake handler
`timescale 1ns/1ps
`default_nettype none
module cpu_model (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic nmiReq,
  output logic eretExec
);
  logic [2:0] delay;
  // A few cycles stand for the handler testing the cause bits
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      delay <= 3'h0;
      eretExec <= 1'b0;
    end else begin
      eretExec <= delay == 3'h1;
      if (nmiReq) begin
        delay <= 3'h4;
      end else if (delay != 3'h0) begin
        delay <= delay - 3'h1;
      end
    end
  end
endmodule
`default_nettype wire

//--- tb_power_save_wake_control.sv
// Self-checking testbench for the power-save wake controller
`timescale 1ns/1ps
`default_nettype none
module tb_power_save_wake_control;
  import pswake_pkg::*;
  logic core_clk, rst_n, porPulse, sysResetPulse, waitExec, eretExec, wdtExpire, debugActive;
  logic failSafeSwitch, oscNeedsStartup, hsel, hwrite, hready, hreadyout, hresp, cpuHalt;
  logic sysClockGate, nmiReq, wdtClear;
  logic [2:0] cpuPrio, failSafeClock, hsize, clockSelect;
  logic [7:0] irqPending, irqEnable, irqRunsInIdle, irqRunsInSleep;
  logic [23:0] irqPrio;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0] htrans, resumeAction, act;
  logic clr;
  int errors = 0;
  int checks = 0;
  assign hready = hreadyout;
  power_save_wake_control dut (.core_clk(core_clk), .rst_n(rst_n), .porPulse(porPulse),
    .sysResetPulse(sysResetPulse), .waitExec(waitExec), .eretExec(eretExec), .cpuPrio(cpuPrio),
    .irqPending(irqPending), .irqEnable(irqEnable), .irqRunsInIdle(irqRunsInIdle),
    .irqRunsInSleep(irqRunsInSleep), .irqPrio(irqPrio), .wdtExpire(wdtExpire),
    .debugActive(debugActive), .failSafeSwitch(failSafeSwitch), .failSafeClock(failSafeClock),
    .oscNeedsStartup(oscNeedsStartup), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .cpuHalt(cpuHalt), .sysClockGate(sysClockGate), .resumeAction(resumeAction),
    .nmiReq(nmiReq), .wdtClear(wdtClear), .clockSelect(clockSelect));
  cpu_model cpu (.core_clk(core_clk), .rst_n(rst_n), .nmiReq(nmiReq), .eretExec(eretExec));
  initial begin
    core_clk = 1'b0;
    forever #2.5 core_clk = ~core_clk;
  end
  // ***************************************************
  // Shared tasks
  // ***************************************************
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      errors++;
      $display("Error at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask
  task automatic finish_test();
    $display("checks %0d, errors %0d", checks, errors);
    if (errors == 0 && checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  task automatic edge_ready();
    int n;
    n = 0;
    @(posedge core_clk);
    while (hready !== 1'b1) begin
      n++;
      if (n > 50) begin
        errors++;
        finish_test();
      end
      @(posedge core_clk);
    end
  endtask
  // Enters just after an edge; returns at the edge that ends the data phase
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= wr;
    hsize <= 3'h2;
    edge_ready();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    edge_ready();
    rd = hrdata;
  endtask
  task automatic wait_resume();
    int n;
    clr = 1'b0;
    for (n = 0; n < 200 && resumeAction === RESUME_NONE; n++) begin
      @(posedge core_clk);
      if (wdtClear === 1'b1) begin
        clr = 1'b1;
      end
    end
    act = resumeAction;
    if (n == 200) begin
      errors++;
      finish_test();
    end
  endtask
  task automatic enter_low(input logic sleepSel, input logic pend);
    bus(1'b1, OSC_CTRL_ADDR, {27'h0, sleepSel, 4'h0});
    waitExec <= 1'b1;
    irqPending <= {7'h0, pend};
    @(posedge core_clk);
    waitExec <= 1'b0;
    repeat (3) @(posedge core_clk);
  endtask
  // ***************************************************
  // Scenarios
  // ***************************************************
  task automatic t_regs();
    bus(1'b0, OSC_DELAY_ADDR, 32'h0);
    check(rd, 32'h10);
    bus(1'b0, RESET_CAUSE_ADDR, 32'h0);
    check(rd, 32'h0);
    bus(1'b0, 8'h10, 32'h0);
    check(rd, 32'h0);
    check(32'(hresp), 32'h0);
    bus(1'b1, OSC_DELAY_ADDR, 32'h2);
    $display("registers test done");
  endtask
  task automatic t_idle();
    enter_low(1'b0, 1'b0);
    bus(1'b0, WAKE_STATUS_ADDR, 32'h0);
    check(rd & 32'h1f, 32'h4);
    for (int i = 0; i < 4; i++) begin
      irqEnable <= {7'h0, i != 0};
      irqRunsInIdle <= {7'h0, i != 1};
      irqPrio <= {21'h0, (i == 2) ? 3'h0 : 3'h2};
      irqPending <= 8'h1;
      repeat (8) @(posedge core_clk);
      check(32'(cpuHalt), 32'h1);
      irqPending <= 8'h0;
      repeat (4) @(posedge core_clk);
    end
    irqPrio <= 24'h5;
    irqPending <= 8'h1;
    wait_resume();
    check(32'(act), 32'h1);
    check(32'(clr), 32'h1);
    irqPending <= 8'h0;
    bus(1'b0, RESET_CAUSE_ADDR, 32'h0);
    check(rd, 32'h4);
    bus(1'b0, RESET_CAUSE_ADDR, 32'h0);
    check(rd, 32'h4);
    bus(1'b1, RESET_CAUSE_ADDR, 32'h0);
    enter_low(1'b1, 1'b1);
    wait_resume();
    check(32'(act), 32'h1);
    irqPending <= 8'h0;
    bus(1'b0, RESET_CAUSE_ADDR, 32'h0);
    check(rd, 32'h8);
    bus(1'b1, RESET_CAUSE_ADDR, 32'h0);
    irqPrio <= 24'h2;
    enter_low(1'b1, 1'b0);
    irqPending <= 8'h1;
    repeat (6) @(posedge core_clk);
    bus(1'b0, WAKE_STATUS_ADDR, 32'h0);
    check(rd & 32'h1f, 32'h4);
    irqPrio <= 24'h5;
    wait_resume();
    check(32'(act), 32'h1);
    irqPending <= 8'h0;
    bus(1'b0, RESET_CAUSE_ADDR, 32'h0);
    check(rd, 32'h4);
    bus(1'b1, RESET_CAUSE_ADDR, 32'h0);
    $display("interrupt wake test done");
  endtask
  task automatic t_wdt();
    enter_low(1'b1, 1'b0);
    check(32'(sysClockGate), 32'h1);
    wdtExpire <= 1'b1;
    wait_resume();
    check(32'(act), 32'h2);
    check(32'(nmiReq), 32'h1);
    wdtExpire <= 1'b0;
    @(posedge core_clk);
    wait_resume();
    check(32'(act), 32'h3);
    bus(1'b0, RESET_CAUSE_ADDR, 32'h0);
    check(rd, 32'h18);
    bus(1'b0, OSC_DELAY_ADDR, 32'h0);
    check(rd, 32'h2);
    bus(1'b1, RESET_CAUSE_ADDR, 32'h0);
    enter_low(1'b0, 1'b0);
    sysResetPulse <= 1'b1;
    @(posedge core_clk);
    sysResetPulse <= 1'b0;
    wait_resume();
    check(32'(act), 32'h2);
    bus(1'b0, RESET_CAUSE_ADDR, 32'h0);
    check(rd, 32'h4);
    enter_low(1'b1, 1'b0);
    porPulse <= 1'b1;
    @(posedge core_clk);
    porPulse <= 1'b0;
    repeat (3) @(posedge core_clk);
    bus(1'b0, RESET_CAUSE_ADDR, 32'h0);
    check(rd, 32'h0);
    $display("watchdog and reset test done");
  endtask
  task automatic t_debug();
    debugActive <= 1'b1;
    bus(1'b1, OSC_CTRL_ADDR, 32'h500);
    @(posedge core_clk);
    check(32'(clockSelect), 32'h0);
    failSafeClock <= 3'h3;
    failSafeSwitch <= 1'b1;
    @(posedge core_clk);
    failSafeSwitch <= 1'b0;
    repeat (2) @(posedge core_clk);
    check(32'(clockSelect), 32'h3);
    debugActive <= 1'b0;
    bus(1'b1, OSC_CTRL_ADDR, 32'h600);
    @(posedge core_clk);
    check(32'(clockSelect), 32'h6);
    $display("debug clock lock test done");
  endtask
  initial begin
    {rst_n, porPulse, sysResetPulse, waitExec, wdtExpire, debugActive, failSafeSwitch} = '0;
    {hsel, hwrite, htrans, hsize, haddr, hwdata, failSafeClock, irqPending} = '0;
    {irqEnable, irqRunsInIdle, irqRunsInSleep, irqPrio} = {8'h1, 8'h1, 8'h1, 24'h2};
    cpuPrio = 3'h2;
    oscNeedsStartup = 1'b1;
    repeat (16) @(posedge core_clk);
    rst_n <= 1'b1;
    @(posedge core_clk);
    t_regs();
    t_idle();
    t_wdt();
    t_debug();
    finish_test();
  end
endmodule
`default_nettype wire
